/* File: verilog/fpe_pkg.sv */
// Package for the flash program/erase host controller: timing constants, commands, states
package fpe_pkg;
    localparam int unsigned CLK_HZ             = 25_000_000;
    localparam int unsigned CLK_NS             = 40;
    // Times in their own units, as printed
    localparam int unsigned SECTOR_LOAD_US     = 100;
    localparam int unsigned CHIP_ERASE_MAX_S   = 35;
    localparam int unsigned SECTOR_ERASE_MAX_S = 12;
    localparam int unsigned PROG_BYTE_MAX_US   = 210;
    localparam int unsigned PROG_WORD_MAX_US   = 360;
    localparam int unsigned PROTECT_PULSE_US   = 10;
    localparam int unsigned UNPROTECT_PULSE_MS = 12;
    localparam int unsigned HV_TRANSITION_US   = 4;
    localparam int unsigned OE_STROBE_SETUP_US = 4;
    localparam int unsigned WE_PULSE_NS        = 55;
    localparam int unsigned WE_HIGH_NS         = 20;
    localparam int unsigned READ_ACCESS_NS     = 120;
    // Derived cycle counts: least times round up
    localparam int unsigned SECTOR_LOAD_CYC = (SECTOR_LOAD_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PROTECT_CYC     = (PROTECT_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned HV_CYC          = (HV_TRANSITION_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned OESP_CYC        = (OE_STROBE_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WE_LOW_CYC      = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WE_HIGH_CYC     = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned READ_CYC        = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
    // Long counts; the erase and unprotect ones are defaults of top-level parameters
    localparam longint unsigned UNPROTECT_CYC    = (64'(UNPROTECT_PULSE_MS) * 1_000_000 + CLK_NS - 1) / CLK_NS;
    localparam longint unsigned CHIP_ERASE_CYC   = 64'(CHIP_ERASE_MAX_S) * CLK_HZ;
    localparam longint unsigned SECTOR_ERASE_CYC = 64'(SECTOR_ERASE_MAX_S) * CLK_HZ;
    localparam longint unsigned PROG_BYTE_CYC    = 64'(PROG_BYTE_MAX_US) * 1000 / CLK_NS;
    localparam longint unsigned PROG_WORD_CYC    = 64'(PROG_WORD_MAX_US) * 1000 / CLK_NS;
    // Bit positions in the status byte
    localparam int unsigned POLL_BIT   = 7;
    localparam int unsigned TOGGLE_BIT = 6;
    localparam int unsigned TIMER_BIT  = 3;
    // Unlock and command codes of the standard command set
    localparam logic [15:0] UNLOCK_ADDR1 = 16'h0555;
    localparam logic [15:0] UNLOCK_ADDR2 = 16'h02AA;
    localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_CHIP     = 8'h10;
    localparam logic [7:0]  CMD_SECTOR   = 8'h30;
    localparam int unsigned SEQ_LEN      = 6;
    localparam logic [2:0]  SEQ_PROG_LEN = 3'h4;
    localparam int unsigned SECTOR_SHIFT = 12;
    localparam int unsigned COUNT_W      = 32;

    typedef enum logic [2:0] {
        FPE_OP_PROGRAM   = 3'b000,
        FPE_OP_CHIP      = 3'b001,
        FPE_OP_SECTOR    = 3'b010,
        FPE_OP_PROTECT   = 3'b011,
        FPE_OP_UNPROTECT = 3'b100
    } fpe_op_t;

    typedef enum logic [3:0] {
        FPE_IDLE    = 4'b0000,
        FPE_CMD     = 4'b0001,
        FPE_MORE    = 4'b0010,
        FPE_POLL    = 4'b0011,
        FPE_POLL2   = 4'b0100,
        FPE_HV      = 4'b0101,
        FPE_PULSE   = 4'b0110,
        FPE_DONE    = 4'b0111,
        FPE_SECWAIT = 4'b1000
    } fpe_state_t;
endpackage

/* File: verilog/fpe_bus_cycle.sv */
// One write or read cycle on the asynchronous flash bus
`timescale 1ns/1ps
`default_nettype none
module fpe_bus_cycle
    import fpe_pkg::*;
#(
    parameter int unsigned DW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          start,
    input  wire logic          is_write,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [DW-1:0] data_in,
    output logic               busy,
    output logic               done,
    output logic [DW-1:0]      rdata,
    output logic               ce_n,
    output logic               oe_n,
    output logic               we_n,
    output logic               data_oe
);
    logic [7:0]    cnt_reg, cnt_next;
    logic [1:0]    ph_reg, ph_next;
    logic          wr_reg, wr_next;
    logic [DW-1:0] rd_reg, rd_next;

    // Phase 1 strobe low (or OE low), phase 2 recovery high
    always_comb begin
        cnt_next = cnt_reg;
        ph_next  = ph_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        done     = 1'b0;
        unique case (ph_reg)
            2'd0: begin
                if (start) begin
                    ph_next  = 2'd1;
                    wr_next  = is_write;
                    cnt_next = is_write ? 8'(WE_LOW_CYC) : 8'(READ_CYC);
                end
            end
            2'd1: begin
                if (cnt_reg == 8'h01) begin
                    ph_next  = 2'd2;
                    cnt_next = 8'(WE_HIGH_CYC);
                    // Sample read data at end of the access; data pins are synchronised upstream
                    if (!wr_reg) rd_next = data_in;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            default: begin
                if (cnt_reg <= 8'h01) begin
                    ph_next = 2'd0;
                    done    = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            ph_reg  <= 2'd0;
            wr_reg  <= 1'b0;
            rd_reg  <= '0;
        end else begin
            cnt_reg <= cnt_next;
            ph_reg  <= ph_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
        end
    end

    assign busy    = (ph_reg != 2'd0);
    assign rdata   = rd_reg;
    assign ce_n    = !(ph_reg != 2'd0);
    assign we_n    = !((ph_reg == 2'd1) && wr_reg);
    assign oe_n    = !((ph_reg == 2'd1) && !wr_reg);
    // Keep driving data through recovery so hold time is met
    assign data_oe = (ph_reg != 2'd0) && wr_reg;
endmodule
`default_nettype wire

/* File: verilog/fpe_host.sv */
// Host controller that runs program, erase and protect sequences on a parallel NOR flash
// Overview of operation
// - Extra sector addresses must follow within the 100 us load window before erasing starts.
// - The protect pulse holds write strobe low for at least 10 us.
// - The unprotect pulse holds write strobe low for at least 12 ms.
// - The host raises high voltage on OE and A9 together and waits 8 us, the 4 us transition plus 4 us OE setup, before the strobe.
`timescale 1ns/1ps
`default_nettype none
module fpe_host
    import fpe_pkg::*;
#(
    parameter int unsigned    AW            = 19,
    parameter int unsigned    DW            = 16,
    parameter longint unsigned CHIP_TMO     = CHIP_ERASE_CYC,
    parameter longint unsigned SECTOR_TMO   = SECTOR_ERASE_CYC,
    parameter longint unsigned UNPROT_CYC   = UNPROTECT_CYC
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          req,
    input  wire fpe_op_t       op,
    input  wire logic          word_mode,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          more_valid,
    input  wire logic [AW-1:0] more_addr,
    output logic               more_ready,
    output logic               ready,
    output logic               done,
    output logic               ok,
    output logic               timeout,
    output logic [AW-1:0]      flash_addr,
    output logic [DW-1:0]      flash_dq_out,
    output logic               flash_dq_oe,
    input  wire logic [DW-1:0] flash_dq_in,
    output logic               flash_ce_n,
    output logic               flash_oe_n,
    output logic               flash_we_n,
    output logic               flash_hv_oe,
    output logic               flash_hv_a9
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic          rs1_reg, rs2_reg;
    logic [DW-1:0] dq1_reg, dq2_reg;
    logic          rst_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rs1_reg <= 1'b0;
            rs2_reg <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end
    assign rst_n = rs2_reg;

    // Data pins come from outside the clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq1_reg <= '0;
            dq2_reg <= '0;
        end else begin
            dq1_reg <= flash_dq_in;
            dq2_reg <= dq1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle engine
    logic          cyc_start, cyc_write, cyc_busy, cyc_done;
    logic [DW-1:0] cyc_wdata, cyc_rdata;
    logic          cyc_ce_n, cyc_oe_n, cyc_we_n, cyc_doe;

    fpe_bus_cycle #(.DW(DW)) u_cyc (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (cyc_start),
        .is_write (cyc_write),
        .wdata    (cyc_wdata),
        .data_in  (dq2_reg),
        .busy     (cyc_busy),
        .done     (cyc_done),
        .rdata    (cyc_rdata),
        .ce_n     (cyc_ce_n),
        .oe_n     (cyc_oe_n),
        .we_n     (cyc_we_n),
        .data_oe  (cyc_doe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    fpe_state_t           st_reg, st_next;
    fpe_op_t              op_reg, op_next;
    logic [2:0]           idx_reg, idx_next;
    logic [AW-1:0]        a_reg, a_next, fa_reg, fa_next;
    logic [DW-1:0]        d_reg, d_next, fd_reg, fd_next;
    logic [COUNT_W+7:0]   tmr_reg, tmr_next;
    logic [COUNT_W+7:0]   tmo_reg, tmo_next;
    logic [DW-1:0]        s1_reg, s1_next;
    logic                 hv_reg, hv_next, ok_reg, ok_next, to_reg, to_next;
    logic                 done_reg, done_next, word_reg, word_next;
    logic [AW-1:0]        seq_a;
    logic [7:0]           seq_d;
    logic [2:0]           seq_len;
    logic                 poll_true, still_toggling;

    // Command table for the unlock sequences
    always_comb begin
        seq_a = AW'(UNLOCK_ADDR1);
        seq_d = UNLOCK_DATA1;
        unique case (idx_reg)
            3'd0: begin seq_a = AW'(UNLOCK_ADDR1); seq_d = UNLOCK_DATA1; end
            3'd1: begin seq_a = AW'(UNLOCK_ADDR2); seq_d = UNLOCK_DATA2; end
            3'd2: begin
                seq_a = AW'(UNLOCK_ADDR1);
                seq_d = (op_reg == FPE_OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE;
            end
            3'd3: begin
                seq_a = (op_reg == FPE_OP_PROGRAM) ? a_reg : AW'(UNLOCK_ADDR1);
                seq_d = (op_reg == FPE_OP_PROGRAM) ? d_reg[7:0] : UNLOCK_DATA1;
            end
            3'd4: begin seq_a = AW'(UNLOCK_ADDR2); seq_d = UNLOCK_DATA2; end
            default: begin
                // sector chosen by upper address lines
                seq_a = (op_reg == FPE_OP_SECTOR) ? a_reg : AW'(UNLOCK_ADDR1);
                seq_d = (op_reg == FPE_OP_SECTOR) ? CMD_SECTOR : CMD_CHIP;
            end
        endcase
    end
    // program is one command, no host verify
    assign seq_len = (op_reg == FPE_OP_PROGRAM) ? SEQ_PROG_LEN : 3'(SEQ_LEN);

    // programming is done when polling bit shows true data
    // erase is done when polling bit reads one
    assign poll_true = (op_reg == FPE_OP_PROGRAM) ? (cyc_rdata[POLL_BIT] == d_reg[POLL_BIT])
                                                  : cyc_rdata[POLL_BIT];
    // compare toggle bit over two successive reads
    assign still_toggling = (cyc_rdata[TOGGLE_BIT] != s1_reg[TOGGLE_BIT]);

    // Main sequencer
    always_comb begin
        st_next   = st_reg;
        op_next   = op_reg;
        idx_next  = idx_reg;
        a_next    = a_reg;
        d_next    = d_reg;
        fa_next   = fa_reg;
        fd_next   = fd_reg;
        tmr_next  = tmr_reg;
        tmo_next  = tmo_reg;
        s1_next   = s1_reg;
        hv_next   = hv_reg;
        ok_next   = ok_reg;
        to_next   = to_reg;
        word_next = word_reg;
        done_next = 1'b0;
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        cyc_wdata = fd_reg;
        more_ready = 1'b0;
        if (tmo_reg != '0) tmo_next = tmo_reg - 1'b1;
        unique case (st_reg)
            FPE_IDLE: begin
                if (req) begin
                    op_next   = op;
                    a_next    = addr;
                    d_next    = wdata;
                    word_next = word_mode;
                    idx_next  = 3'd0;
                    ok_next   = 1'b0;
                    to_next   = 1'b0;
                    if (op == FPE_OP_PROTECT || op == FPE_OP_UNPROTECT) begin
                        // raise high voltage, wait for transition and OE setup
                        hv_next  = 1'b1;
                        fa_next  = addr;
                        tmr_next = (COUNT_W+8)'(HV_CYC + OESP_CYC);
                        st_next  = FPE_HV;
                    end else begin
                        st_next = FPE_CMD;
                    end
                end
            end
            FPE_CMD: begin
                if (!cyc_busy) begin
                    fa_next   = seq_a;
                    fd_next   = (idx_reg == 3'd3 && op_reg == FPE_OP_PROGRAM) ? d_reg : DW'(seq_d);
                    cyc_wdata = fd_next;
                    cyc_start = 1'b1;
                    st_next   = FPE_SECWAIT;
                end
            end
            FPE_SECWAIT: begin
                if (cyc_done) begin
                    if (idx_reg == seq_len - 3'd1) begin
                        // chip erase time-out sector erase program
                        unique case (op_reg)
                            FPE_OP_CHIP:    tmo_next = (COUNT_W+8)'(CHIP_TMO);
                            FPE_OP_SECTOR:  tmo_next = (COUNT_W+8)'(SECTOR_TMO);
                            default:        tmo_next = word_reg ? (COUNT_W+8)'(PROG_WORD_CYC)
                                                                : (COUNT_W+8)'(PROG_BYTE_CYC);
                        endcase
                        // more sector addresses within the load window
                        tmr_next = (COUNT_W+8)'(SECTOR_LOAD_CYC);
                        st_next  = (op_reg == FPE_OP_SECTOR) ? FPE_MORE : FPE_POLL;
                    end else begin
                        idx_next = idx_reg + 3'd1;
                        st_next  = FPE_CMD;
                    end
                end
            end
            FPE_MORE: begin
                // Extra sector loads are written back to back with margin to spare
                if (tmr_reg != '0) tmr_next = tmr_reg - 1'b1;
                if (!cyc_busy && more_valid && tmr_reg > (COUNT_W+8)'(WE_LOW_CYC + WE_HIGH_CYC + 2)) begin
                    // load window timer still above one write cycle, extra sector accepted
                    more_ready = 1'b1;
                    fa_next    = more_addr;
                    fd_next    = DW'(CMD_SECTOR);
                    cyc_wdata  = DW'(CMD_SECTOR);
                    cyc_start  = 1'b1;
                // Window spent or nothing offered: a late offer must not stall the erase
                end else if (!cyc_busy) begin
                    st_next = FPE_POLL;
                end
            end
            FPE_POLL: begin
                fa_next = a_reg;
                if (!cyc_busy && !cyc_start) begin
                    cyc_write = 1'b0;
                    cyc_start = 1'b1;
                    st_next   = FPE_POLL2;
                end
            end
            FPE_POLL2: begin
                cyc_write = 1'b0;
                if (cyc_done) begin
                    s1_next = cyc_rdata;
                    // device busy, no new command is issued until status settles
                    if (poll_true && !still_toggling) begin
                        ok_next = 1'b1;
                        st_next = FPE_DONE;
                    end else if (tmo_reg == '0) begin
                        to_next = 1'b1;
                        st_next = FPE_DONE;
                    end else begin
                        st_next = FPE_POLL;
                    end
                end
            end
            FPE_HV: begin
                if (tmr_reg != '0) begin
                    tmr_next = tmr_reg - 1'b1;
                end else begin
                    tmr_next = (op_reg == FPE_OP_PROTECT) ? (COUNT_W+8)'(PROTECT_CYC)
                                                          : (COUNT_W+8)'(UNPROT_CYC);
                    st_next  = FPE_PULSE;
                end
            end
            FPE_PULSE: begin
                if (tmr_reg > (COUNT_W+8)'(1)) begin
                    tmr_next = tmr_reg - 1'b1;
                end else begin
                    // High voltage held through DONE so the strobe rises under it
                    ok_next = 1'b1;
                    st_next = FPE_DONE;
                end
            end
            FPE_DONE: begin
                // device back in array read; host is ready again
                done_next = 1'b1;
                hv_next   = 1'b0;
                st_next   = FPE_IDLE;
            end
            default: st_next = FPE_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg   <= FPE_IDLE;
            op_reg   <= FPE_OP_PROGRAM;
            idx_reg  <= 3'd0;
            a_reg    <= '0;
            d_reg    <= '0;
            fa_reg   <= '0;
            fd_reg   <= '0;
            tmr_reg  <= '0;
            tmo_reg  <= '0;
            s1_reg   <= '0;
            hv_reg   <= 1'b0;
            ok_reg   <= 1'b0;
            to_reg   <= 1'b0;
            done_reg <= 1'b0;
            word_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            op_reg   <= op_next;
            idx_reg  <= idx_next;
            a_reg    <= a_next;
            d_reg    <= d_next;
            fa_reg   <= fa_next;
            fd_reg   <= fd_next;
            tmr_reg  <= tmr_next;
            tmo_reg  <= tmo_next;
            s1_reg   <= s1_next;
            hv_reg   <= hv_next;
            ok_reg   <= ok_next;
            to_reg   <= to_next;
            done_reg <= done_next;
            word_reg <= word_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs; the protect pulse drives CE and WE low for its whole length
    assign ready        = (st_reg == FPE_IDLE);
    assign done         = done_reg;
    assign ok           = ok_reg;
    assign timeout      = to_reg;
    assign flash_addr   = fa_reg;
    assign flash_dq_out = fd_reg;
    assign flash_dq_oe  = cyc_doe;
    assign flash_hv_oe  = hv_reg;
    assign flash_hv_a9  = hv_reg;
    assign flash_ce_n   = cyc_ce_n && !(st_reg == FPE_PULSE || st_reg == FPE_HV || (st_reg == FPE_DONE && hv_reg));
    assign flash_oe_n   = cyc_oe_n;
    assign flash_we_n   = cyc_we_n && (st_reg != FPE_PULSE);
endmodule
`default_nettype wire

/* File: tb/fpe_host_sva.sv */
// Port checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fpe_host_sva
    import fpe_pkg::*;
#(
    parameter longint unsigned UNPROT_CYC = UNPROTECT_CYC
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        req,
    input wire logic        ready,
    input wire logic        done,
    input wire logic        ok,
    input wire logic        timeout,
    input wire logic        more_valid,
    input wire logic        more_ready,
    input wire logic [18:0] flash_addr,
    input wire logic        flash_dq_oe,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic        flash_hv_oe
);
    logic [31:0] low_reg;
    logic [31:0] low_next;
    logic [31:0] hv_reg;
    logic [31:0] hv_next;
    ////////////////////////////////////////////////////////////////
    // Pulse and setup lengths counted in cycles, too long to unroll
    always_comb begin
        low_next = flash_we_n ? 32'h0000_0000 : low_reg + 32'h0000_0001;
        hv_next  = flash_hv_oe ? hv_reg + 32'h0000_0001 : 32'h0000_0000;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_reg <= 32'h0000_0000;
            hv_reg  <= 32'h0000_0000;
        end else begin
            low_reg <= low_next;
            hv_reg  <= hv_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_prot_pulse: assert property ($rose(flash_we_n) && flash_hv_oe && !flash_addr[6] |-> low_reg >= PROTECT_CYC)
        else $error("protect strobe too short");
    a_unprot_pulse: assert property ($rose(flash_we_n) && flash_hv_oe && flash_addr[6] |-> low_reg >= 32'(UNPROT_CYC))
        else $error("unprotect strobe too short");
    a_oe_setup: assert property ($fell(flash_we_n) && flash_hv_oe |-> hv_reg >= HV_CYC + OESP_CYC)
        else $error("high voltage setup too short");
    a_more_offer: assert property (more_ready |-> more_valid && !ready)
        else $error("extra sector taken unoffered");
    a_tmo_done: assert property ($rose(timeout) |=> done)
        else $error("timeout without done");
    a_req_clear: assert property (ready && req |=> !ok && !timeout)
        else $error("status not cleared by request");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_idle_quiet: assert property (ready |-> flash_we_n && !flash_dq_oe)
        else $error("write while idle");
    a_dq_no_clash: assert property (flash_dq_oe |-> flash_oe_n)
        else $error("data driven while reading");
    c_ok: cover property (done && ok);
    c_tmo: cover property (done && timeout);
    c_more: cover property (more_ready);
endmodule
`default_nettype wire

/* File: tb/fpe_flash_model.sv */
// Behavioural flash device with status polling
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model
    import fpe_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [18:0] addr,
    input  wire logic [15:0] dq_out,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        hv_oe,
    input  wire logic        hv_a9,
    output logic      [15:0] dq_in
);
    logic [15:0] mem = 16'hFFFF;
    logic [18:0] ma = '0;
    logic [15:0] lv = '0;
    logic        prog = 0, er = 0, tgl = 0, hit = 0, prot = 0, we_q = 1, oe_q = 1;
    logic [7:0]  pd = '0;
    int          busy = 0, win = 0;
    logic [15:0] val;
    // status while busy; array data after
    assign val = hv_a9 ? {15'h0000, prot} : (busy != 0 || win != 0) ?
        {8'h00, er ? 1'b0 : ~pd[7], tgl, 2'b00, win == 0, 3'b000} : (addr == ma ? mem : 16'hFFFF);
    // Released lines show the inverse of the last value, never a kind guess
    assign dq_in = oe_n ? ~lv : val;
    always @(posedge clk) begin
        we_q <= we_n;
        oe_q <= oe_n;
        if (!oe_n) lv <= val;
        if (!oe_n && oe_q) tgl <= ~tgl;
        // writes ignored while busy; internal verify
        if (we_n && !we_q && !ce_n && busy == 0) begin
            if (hv_oe) prot <= !addr[6];
            else if (prog) begin
                ma <= addr;
                mem <= dq_out;
                pd <= dq_out[7:0];
                er <= 0;
                busy <= slow ? 400 : 60;
            end else if (dq_out[7:0] == CMD_CHIP) begin
                mem <= 16'hFFFF;
                er <= 1;
                busy <= slow ? 400 : 60;
            // each sector address reopens the load window
            end else if (dq_out[7:0] == CMD_SECTOR) begin
                win <= SECTOR_LOAD_CYC;
                er <= 1;
                hit <= hit | (addr[18:12] == ma[18:12]);
            end
            prog <= !hv_oe && !prog && dq_out[7:0] == CMD_PROGRAM;
        end
        if (win == 1) begin
            busy <= 60;
            if (hit) mem <= 16'hFFFF;
            hit <= 0;
        end
        if (win != 0) win <= win - 1;
        else if (busy != 0) busy <= busy - 1;
    end
endmodule
`default_nettype wire

/* File: tb/tb_fpe_host.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_fpe_host;
    import fpe_pkg::*;
    logic clk = 0, nrst = 0, req = 0, word_mode = 0, more_valid = 0, slow = 0, took;
    fpe_op_t op = FPE_OP_PROGRAM;
    logic [18:0] addr = '0, more_addr = '0, flash_addr;
    logic [15:0] wdata = '0, dq_out, dq_in;
    logic more_ready, ready, done, ok, timeout, dq_oe, ce_n, oe_n, we_n, hv_oe, hv_a9;
    int fails = 0, n_checks = 0;
    always #20 clk = ~clk;
    fpe_host #(.CHIP_TMO(200), .SECTOR_TMO(4000), .UNPROT_CYC(200)) DUT (.clk(clk), .nrst(nrst), .req(req),
        .op(op), .word_mode(word_mode), .addr(addr), .wdata(wdata), .more_valid(more_valid),
        .more_addr(more_addr), .more_ready(more_ready), .ready(ready), .done(done), .ok(ok),
        .timeout(timeout), .flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
        .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_hv_oe(hv_oe), .flash_hv_a9(hv_a9));
    fpe_flash_model u_flash (.clk(clk), .slow(slow), .addr(flash_addr), .dq_out(dq_out), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .hv_oe(hv_oe), .hv_a9(hv_a9), .dq_in(dq_in));
    task automatic chk(input logic c, input string m);
        n_checks++;
        if (c !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // One request, then a bounded wait for done
    task automatic run(input fpe_op_t o, input logic [18:0] a, input logic [15:0] d, input logic okx);
        @(posedge clk);
        req <= 1;
        op <= o;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        req <= 0;
        for (int i = 0; i < 6000; i++) begin
            @(posedge clk);
            if (more_ready === 1'b1) begin
                took = 1;
                more_valid <= 0;
            end
            #1;
            if (done === 1'b1) break;
        end
        chk(done, "no done");
        chk(ok === okx && timeout === !okx, "wrong result");
    endtask
    task automatic t_program();
        run(FPE_OP_PROGRAM, 19'h0_3000, 16'h5A3C, 1);
        chk(u_flash.mem === 16'h5A3C, "data not stored");
    endtask
    task automatic t_chip();
        run(FPE_OP_CHIP, 19'h0_0000, 16'h0000, 1);
        chk(u_flash.mem === 16'hFFFF, "chip not erased");
    endtask
    task automatic t_sector();
        word_mode <= 1;
        run(FPE_OP_PROGRAM, 19'h0_3000, 16'h1234, 1);
        took = 0;
        more_addr <= 19'h0_3000;
        more_valid <= 1;
        run(FPE_OP_SECTOR, 19'h0_1000, 16'h0000, 1);
        chk(took, "extra sector not taken");
        chk(u_flash.mem === 16'hFFFF, "sector not erased");
    endtask
    task automatic t_protect();
        run(FPE_OP_PROTECT, 19'h0_0000, 16'h0000, 1);
        chk(u_flash.prot === 1'b1, "sector not protected");
        run(FPE_OP_UNPROTECT, 19'h0_0040, 16'h0000, 1);
        chk(u_flash.prot === 1'b0, "chip not unprotected");
    endtask
    task automatic t_timeout();
        slow <= 1;
        run(FPE_OP_CHIP, 19'h0_0000, 16'h0000, 0);
        slow <= 0;
    endtask
    task automatic wrap_up();
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1;
        repeat (3) @(posedge clk);
        t_program();
        t_chip();
        t_sector();
        t_protect();
        t_timeout();
        wrap_up();
    end
    // Watchdog well beyond the slowest expected sequence
    initial begin
        #(40 * 60000);
        fails++;
        wrap_up();
    end
endmodule
bind fpe_host fpe_host_sva #(.UNPROT_CYC(UNPROT_CYC)) u_sva (.clk(clk), .nrst(nrst), .req(req), .ready(ready),
    .done(done), .ok(ok), .timeout(timeout), .more_valid(more_valid), .more_ready(more_ready),
    .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_hv_oe(flash_hv_oe));
`default_nettype wire
